// *** hdl/opexec_core.sv ***
// execution unit for call-via-working, complement, clear and decrement
// Notes on behaviour
// - call via working pushes pc plus one onto return stack before pc changes
// - call loads pc low byte from working, high bits from upper latch; flags kept
// - call via working takes two instruction cycles
// - complement inverts file register; dest 0 to working, 1 back; zero updated
// - clear register writes zero to file register and sets zero flag
// - decrement subtracts one; dest selects working or file; zero from result
// - clear working writes zero to working and sets zero flag
`timescale 1ns/1ps
`default_nettype none
module opexec_core
(
    input  wire logic                          i_core_clk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_instr_valid,
    input  wire opexec_pkg::instr_t            i_instr,
    input  wire logic [opexec_pkg::DATA_W-1:0] i_file_rdata,
    input  wire logic                          i_latch_we,
    input  wire logic [6:0]                    i_latch_wdata,
    output logic                               o_instr_ready,
    output opexec_pkg::file_wr_t               o_file_wr,
    output logic [opexec_pkg::ADDR_W-1:0]      o_file_raddr,
    output logic [opexec_pkg::DATA_W-1:0]      o_working,
    output logic                               o_zero,
    output logic [opexec_pkg::PC_W-1:0]        o_pc,
    output logic [opexec_pkg::PC_W-1:0]        o_return_stack_head,
    output logic                               o_busy
);
    import opexec_pkg::*;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_CALL = 2'b10
    } state_t;

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == ZERO_BYTE);
    endfunction

    state_t          state_ff;
    state_t          nxt_state;
    logic [DATA_W-1:0] w_ff;
    logic [DATA_W-1:0] nxt_w;
    logic            z_ff;
    logic            nxt_z;
    logic [PC_W-1:0] pc_ff;
    logic [PC_W-1:0] nxt_pc;
    logic [6:0]      pc_upper_latch_ff;
    logic [6:0]      nxt_pc_upper_latch;
    file_wr_t        wr_ff;
    file_wr_t        nxt_wr;
    logic            push;
    logic [PC_W-1:0] push_addr;
    logic [DATA_W-1:0] result;
    logic            take;
    logic [SP_W-1:0] depth;

    // new work is accepted only when the call's second cycle is done
    assign o_instr_ready = (state_ff == ST_IDLE);
    assign take          = i_instr_valid && o_instr_ready;
    assign o_file_raddr  = i_instr.addr;

    always_comb
    begin
        nxt_state          = state_ff;
        nxt_w              = w_ff;
        nxt_z              = z_ff;
        nxt_pc             = pc_ff;
        nxt_pc_upper_latch = i_latch_we ? i_latch_wdata : pc_upper_latch_ff;
        nxt_wr             = '0;
        push               = 1'b0;
        push_addr          = pc_ff + 15'h0001;
        result             = ZERO_BYTE;
        case (state_ff)
            ST_IDLE:
            begin
                if (take)
                begin
                    case (i_instr.op)
                        OP_CALL_VIA_WORKING:
                        begin
                            push      = 1'b1;
                            nxt_state = ST_CALL;
                        end
                        OP_COMPLEMENT_REGISTER, OP_DECREMENT_REGISTER:
                        begin
                            result = (i_instr.op == OP_COMPLEMENT_REGISTER)
                                   ? ~i_file_rdata
                                   : i_file_rdata - 8'h01;
                            nxt_z  = is_zero(result);
                            if (i_instr.dest_reg)
                            begin
                                nxt_wr.we   = 1'b1;
                                nxt_wr.addr = i_instr.addr;
                                nxt_wr.data = result;
                            end
                            else
                            begin
                                nxt_w = result;
                            end
                            nxt_pc = pc_ff + 15'h0001;
                        end
                        OP_CLEAR_REGISTER:
                        begin
                            nxt_wr.we   = 1'b1;
                            nxt_wr.addr = i_instr.addr;
                            nxt_wr.data = ZERO_BYTE;
                            nxt_z       = 1'b1;
                            nxt_pc      = pc_ff + 15'h0001;
                        end
                        OP_CLEAR_WORKING:
                        begin
                            nxt_w  = ZERO_BYTE;
                            nxt_z  = 1'b1;
                            nxt_pc = pc_ff + 15'h0001;
                        end
                        default:
                        begin
                            nxt_pc = pc_ff + 15'h0001;
                        end
                    endcase
                end
            end
            ST_CALL:
            begin
                // second cycle: pc swapped only after the push has landed
                nxt_pc    = {pc_upper_latch_ff, w_ff};
                nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            state_ff          <= ST_IDLE;
            w_ff              <= W_RESET;
            z_ff              <= Z_RESET;
            pc_ff             <= PC_RESET;
            pc_upper_latch_ff <= LATCH_RESET;
            wr_ff             <= '0;
        end
        else
        begin
            state_ff          <= nxt_state;
            w_ff              <= nxt_w;
            z_ff              <= nxt_z;
            pc_ff             <= nxt_pc;
            pc_upper_latch_ff <= nxt_pc_upper_latch;
            wr_ff             <= nxt_wr;
        end
    end

    return_stack u_stack
    (
        .i_core_clk  (i_core_clk),
        .i_rst_n     (i_rst_n),
        .i_push      (push),
        .i_push_addr (push_addr),
        .o_head      (o_return_stack_head),
        .o_depth     (depth)
    );

    assign o_file_wr = wr_ff;
    assign o_working = w_ff;
    assign o_zero    = z_ff;
    assign o_pc      = pc_ff;
    assign o_busy    = (state_ff == ST_CALL);

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    call_push_a: assert property (take && i_instr.op == OP_CALL_VIA_WORKING |=>
        o_return_stack_head == $past(pc_ff) + 15'h0001 && pc_ff == $past(pc_ff))
        else $error("call did not push return address first");
    call_target_a: assert property (take && i_instr.op == OP_CALL_VIA_WORKING
        && !i_latch_we |=> ##1 pc_ff == {$past(pc_upper_latch_ff, 2), $past(w_ff, 2)})
        else $error("call target wrong");
    call_flags_a: assert property (take && i_instr.op == OP_CALL_VIA_WORKING
        |=> $stable(z_ff) [*2])
        else $error("call changed zero flag");
    call_two_a: assert property (take && i_instr.op == OP_CALL_VIA_WORKING
        |=> !o_instr_ready ##1 o_instr_ready)
        else $error("call not two cycles");
    comp_res_a: assert property (take && i_instr.op == OP_COMPLEMENT_REGISTER
        && !i_instr.dest_reg |=> w_ff == ~$past(i_file_rdata))
        else $error("complement to working wrong");
    clear_register_a: assert property (take && i_instr.op == OP_CLEAR_REGISTER
        |=> o_file_wr.we && o_file_wr.data == 8'h00 && z_ff)
        else $error("clear register wrong");
    dec_res_a: assert property (take && i_instr.op == OP_DECREMENT_REGISTER
        && i_instr.dest_reg |=> o_file_wr.we && o_file_wr.data == $past(i_file_rdata) - 8'h01
        && w_ff == $past(w_ff))
        else $error("decrement to file wrong");
    clear_working_a: assert property (take && i_instr.op == OP_CLEAR_WORKING
        |=> w_ff == 8'h00 && z_ff)
        else $error("clear working wrong");
    zero_flag_a: assert property (take && (i_instr.op == OP_DECREMENT_REGISTER
        || i_instr.op == OP_COMPLEMENT_REGISTER) |=> o_instr_ready
        && z_ff == (o_file_wr.we ? o_file_wr.data == 8'h00 : w_ff == 8'h00))
        else $error("zero flag mismatch");

    call_depth_a: assert property (take && i_instr.op == OP_CALL_VIA_WORKING
        |=> depth == $past(depth) + 4'h1)
        else $error("call did not grow return stack");
    data_single_a: assert property (take && i_instr.op != OP_CALL_VIA_WORKING
        |=> o_instr_ready && !o_busy)
        else $error("data op took more than one cycle");

    call_c: cover property (take && i_instr.op == OP_CALL_VIA_WORKING ##2 o_instr_ready);
    dec_zero_c: cover property (take && i_instr.op == OP_DECREMENT_REGISTER ##1 z_ff);
    comp_file_c: cover property (take && i_instr.op == OP_COMPLEMENT_REGISTER
        && i_instr.dest_reg);
    clear_working_c: cover property (take && i_instr.op == OP_CLEAR_WORKING);
endmodule
`default_nettype wire

// *** hdl/opexec_pkg.sv ***
// shared constants and carrier types for the call/clear/complement execution unit
package opexec_pkg;
    localparam int        DATA_W        = 8;
    localparam int        PC_W          = 15;
    localparam int        ADDR_W        = 7;
    localparam int        STACK_DEPTH   = 16;
    localparam int        SP_W          = 4;
    // instruction cycles
    localparam int        CALL_CYCLES   = 2;
    localparam int        SINGLE_CYCLES = 1;
    localparam logic [7:0]      ZERO_BYTE  = 8'h00;
    localparam logic [7:0]      W_RESET    = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET   = 15'h0000;
    localparam logic [6:0]      LATCH_RESET = 7'h00;
    localparam logic [SP_W-1:0] SP_RESET   = 4'h0;
    localparam logic            Z_RESET    = 1'b0;
    // field positions inside the target pc
    localparam int        PC_LO_MSB     = 7;
    localparam int        PC_HI_LSB     = 8;

    typedef enum logic [2:0]
    {
        OP_NONE,
        OP_CALL_VIA_WORKING,
        OP_COMPLEMENT_REGISTER,
        OP_CLEAR_REGISTER,
        OP_DECREMENT_REGISTER,
        OP_CLEAR_WORKING
    } op_t;

    typedef struct packed
    {
        op_t              op;
        logic [ADDR_W-1:0] addr;
        logic             dest_reg;
    } instr_t;

    typedef struct packed
    {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } file_wr_t;
endpackage

// *** hdl/return_stack.sv ***
// hardware return stack held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module return_stack
(
    input  wire logic                        i_core_clk,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_push,
    input  wire logic [opexec_pkg::PC_W-1:0] i_push_addr,
    output logic      [opexec_pkg::PC_W-1:0] o_head,
    output logic      [opexec_pkg::SP_W-1:0] o_depth
);
    import opexec_pkg::*;

    logic [PC_W-1:0] mem_ff [STACK_DEPTH];
    logic [PC_W-1:0] nxt_mem [STACK_DEPTH];
    logic [SP_W-1:0] sp_ff;
    logic [SP_W-1:0] nxt_sp;
    logic [PC_W-1:0] head_ff;
    logic [PC_W-1:0] nxt_head;

    // overflow wraps, as a circular stack; no overflow flag is kept here
    always_comb
    begin
        nxt_mem  = mem_ff;
        nxt_sp   = sp_ff;
        nxt_head = head_ff;
        if (i_push)
        begin
            nxt_mem[sp_ff] = i_push_addr;
            nxt_sp         = sp_ff + 4'h1;
            nxt_head       = i_push_addr;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < STACK_DEPTH; i++)
            begin
                mem_ff[i] <= PC_RESET;
            end
            sp_ff   <= SP_RESET;
            head_ff <= PC_RESET;
        end
        else
        begin
            mem_ff  <= nxt_mem;
            sp_ff   <= nxt_sp;
            head_ff <= nxt_head;
        end
    end

    assign o_head  = head_ff;
    assign o_depth = sp_ff;
endmodule
`default_nettype wire

// *** tb/cpu_call_clear_complement_ops_test.sv ***
// self-checking bench for the call/clear/complement execution unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin check_count++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, got, exp); end end
module cpu_call_clear_complement_ops_test;
    import opexec_pkg::*;
    logic              clk         = 1'b0;
    logic              rst_n       = 1'b0;
    logic              valid       = 1'b0;
    logic              latch_we    = 1'b0;
    instr_t            instr       = '0;
    logic [7:0]        rdata       = 8'h00;
    logic [6:0]        latch_wdata = 7'h00;
    logic              ready;
    file_wr_t          fwr;
    logic [ADDR_W-1:0] raddr;
    logic [7:0]        working;
    logic              zero;
    logic [PC_W-1:0]   pc;
    logic [PC_W-1:0]   head;
    logic              busy;
    logic [PC_W-1:0]   exp_pc      = '0;
    int                err_count   = 0;
    int                check_count = 0;

    opexec_core DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_instr_valid(valid), .i_instr(instr),
        .i_file_rdata(rdata), .i_latch_we(latch_we), .i_latch_wdata(latch_wdata),
        .o_instr_ready(ready), .o_file_wr(fwr), .o_file_raddr(raddr), .o_working(working),
        .o_zero(zero), .o_pc(pc), .o_return_stack_head(head), .o_busy(busy));

    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // bounded wait so a stuck busy ends the run instead of hanging it
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 10)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (ready !== 1'b1)
        begin
            err_count++;
            $display("ERROR t=%0t ready never returned", $time);
            summarize();
        end
    endtask

    task automatic issue(input op_t o, input logic [6:0] a, input logic d, input logic [7:0] r);
        @(posedge clk);
        #1;
        wait_ready();
        @(posedge clk);
        valid <= 1'b1;
        instr.op <= o;
        instr.addr <= a;
        instr.dest_reg <= d;
        rdata <= r;
        #1;
        `CHK(raddr, a)
        @(posedge clk);
        valid <= 1'b0;
        #1;
    endtask

    task automatic do_op(input op_t o, input logic [6:0] a, input logic d, input logic [7:0] r,
                         input logic [7:0] ew, input logic ez, input logic ewe,
                         input logic [7:0] ed);
        issue(o, a, d, r);
        exp_pc = exp_pc + 15'h0001;
        `CHK(working, ew)
        `CHK(zero, ez)
        `CHK(fwr.we, ewe)
        `CHK(pc, exp_pc)
        if (ewe)
        begin
            `CHK(fwr.addr, a)
            `CHK(fwr.data, ed)
        end
    endtask

    task automatic t_reset();
        `CHK(pc, 15'h0000)
        `CHK({working, zero, fwr.we, busy, ready}, 12'h001)
        `CHK(head, 15'h0000)
    endtask

    task automatic t_decrement();
        do_op(OP_DECREMENT_REGISTER, 7'h10, 1'b0, 8'h00, 8'hff, 1'b0, 1'b0, 8'h00);
        do_op(OP_DECREMENT_REGISTER, 7'h7f, 1'b1, 8'h01, 8'hff, 1'b1, 1'b1, 8'h00);
        do_op(OP_DECREMENT_REGISTER, 7'h00, 1'b1, 8'h80, 8'hff, 1'b0, 1'b1, 8'h7f);
    endtask

    task automatic t_complement();
        do_op(OP_COMPLEMENT_REGISTER, 7'h05, 1'b1, 8'hff, 8'hff, 1'b1, 1'b1, 8'h00);
        do_op(OP_COMPLEMENT_REGISTER, 7'h7f, 1'b0, 8'h5a, 8'ha5, 1'b0, 1'b0, 8'h00);
    endtask

    task automatic t_clear();
        do_op(OP_CLEAR_REGISTER, 7'h7f, 1'b1, 8'h33, 8'ha5, 1'b1, 1'b1, 8'h00);
        do_op(OP_DECREMENT_REGISTER, 7'h01, 1'b0, 8'h3d, 8'h3c, 1'b0, 1'b0, 8'h00);
        do_op(OP_CLEAR_WORKING, 7'h22, 1'b0, 8'h77, 8'h00, 1'b1, 1'b0, 8'h00);
    endtask

    // a request held during the busy cycle must be dropped, not queued
    task automatic t_call();
        do_op(OP_DECREMENT_REGISTER, 7'h02, 1'b0, 8'hc4, 8'hc3, 1'b0, 1'b0, 8'h00);
        do_op(OP_COMPLEMENT_REGISTER, 7'h03, 1'b1, 8'hff, 8'hc3, 1'b1, 1'b1, 8'h00);
        @(posedge clk);
        latch_we <= 1'b1;
        latch_wdata <= 7'h5a;
        @(posedge clk);
        latch_we <= 1'b0;
        issue(OP_CALL_VIA_WORKING, 7'h00, 1'b0, 8'h00);
        instr.op <= OP_CLEAR_WORKING;
        valid <= 1'b1;
        `CHK(head, exp_pc + 15'h0001)
        `CHK(pc, exp_pc)
        `CHK({busy, ready}, 2'b10)
        @(posedge clk);
        valid <= 1'b0;
        #1;
        `CHK(pc, {7'h5a, 8'hc3})
        `CHK({zero, working}, 9'h1c3)
        `CHK({busy, ready}, 2'b01)
        exp_pc = {7'h5a, 8'hc3};
        do_op(OP_NONE, 7'h00, 1'b0, 8'h00, 8'hc3, 1'b1, 1'b0, 8'h00);
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        #1;
        t_reset();
        @(posedge clk);
        rst_n <= 1'b1;
        t_decrement();
        t_complement();
        t_clear();
        t_call();
        summarize();
    end
endmodule
`default_nettype wire
